/* vic_vectored_irq_ctrl.sv */
// Vectored interrupt controller with AHB-Lite register slave
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
// Summary of operation
// - Thirty-two request inputs each carry a software class bit choosing fast or vectored service.
// - Fast-class requests drive the fast output alone and never enter the vectored arbitration.
// - The fast output is the OR of all active fast-class requests.
// - A readable word shows which fast-class sources are requesting now.
// - Every input not in the fast class is a vectored request with a software priority.
// - Among vectored requests of equal priority the lowest channel number wins.
// - The normal output is the OR of all active vectored requests.
// - A readable register gives the service address of the winning vectored request.
// - Each of the 46 port pins can raise an interrupt on rising, falling or both edges.
// - Port edge requests merge with the third external interrupt line into its one channel.
// - Class and priority can be rewritten at run time and take effect without reset.
module vic_vectored_irq_ctrl
	import vic_pkg::*;
#(
	parameter int PIN_COUNT = 46,
	parameter int PRIO_WIDTH = 4,
	parameter int EXT_CHANNEL = 17
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [VIC_CHANNELS-1:0] periph_req,
	input wire logic [PIN_COUNT-1:0] port_pins,
	output logic fast_interrupt_request,
	output logic normal_interrupt_request,
	output logic edge_irq
);
	localparam int PADW = 32 * VIC_PIN_WORDS;

	// ****************************************
	// Port edge detection
	// ****************************************
	logic [PIN_COUNT-1:0] rise, fall;
	logic [PADW-1:0] rise_w, fall_w, edge_hit;

	vic_edge_detect #(.WIDTH(PIN_COUNT)) u_edge (
		.clk(clk),
		.nrst(nrst),
		.pins(port_pins),
		.rise(rise),
		.fall(fall)
	);

	// ****************************************
	// Register state
	// ****************************************
	logic [31:0] enable_q, enable_d;
	logic [31:0] class_q, class_d;
	logic [31:0] def_vect_q, def_vect_d;
	logic [31:0] vect_addr_q, vect_addr_d;
	logic [31:0] vect_q [VIC_CHANNELS];
	logic [31:0] vect_d [VIC_CHANNELS];
	logic [PRIO_WIDTH-1:0] prio_q [VIC_CHANNELS];
	logic [PRIO_WIDTH-1:0] prio_d [VIC_CHANNELS];
	logic [PADW-1:0] edge_stat_q, edge_stat_d;
	logic [PADW-1:0] edge_mask_q, edge_mask_d;
	logic [PADW-1:0] rise_en_q, rise_en_d;
	logic [PADW-1:0] fall_en_q, fall_en_d;
	logic edge_irq_q, edge_irq_d;
	logic fast_irq_q, fast_irq_d;
	logic irq_q, irq_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic hreadyout_q, hreadyout_d;
	logic hresp_q, hresp_d;
	logic wr_pend_q, wr_pend_d;
	logic rd_pend_q, rd_pend_d;
	logic [11:0] addr_q, addr_d;

	// ****************************************
	// Request classification and arbitration
	// ****************************************
	logic [31:0] raw_req, active, fast_active, norm_active;
	logic win_valid;
	logic [4:0] win_idx;
	logic [PRIO_WIDTH-1:0] win_prio;

	always_comb begin
		rise_w = '0;
		fall_w = '0;
		rise_w[PIN_COUNT-1:0] = rise;
		fall_w[PIN_COUNT-1:0] = fall;
		edge_hit = (rise_w & rise_en_q) | (fall_w & fall_en_q);
		raw_req = periph_req;
		raw_req[EXT_CHANNEL] = periph_req[EXT_CHANNEL] | edge_irq_q;
		active = raw_req & enable_q;
		fast_active = active & class_q;
		norm_active = active & ~class_q;
	end

	always_comb begin
		win_valid = 1'b0;
		win_idx = 5'h00;
		win_prio = '1;
		for (int i = 0; i < VIC_CHANNELS; i++) begin
			if (norm_active[i] && (!win_valid || prio_q[i] < win_prio)) begin
				win_valid = 1'b1;
				win_idx = 5'(i);
				win_prio = prio_q[i];
			end
		end
	end

	// ****************************************
	// Register read mux
	// ****************************************
	function automatic logic [31:0] rd_mux(input logic [11:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		if (a[11:8] == VIC_PAGE_VECT && a[7] == 1'b0) begin
			v = vect_q[a[6:2]];
		end else if (a[11:8] == VIC_PAGE_PRIO && a[7] == 1'b0) begin
			v = 32'(prio_q[a[6:2]]);
		end else begin
			case (a)
				VIC_OFF_RAW: v = raw_req;
				VIC_OFF_ENABLE: v = enable_q;
				VIC_OFF_CLASS: v = class_q;
				VIC_OFF_FAST_STAT: v = fast_active;
				VIC_OFF_NORM_STAT: v = norm_active;
				VIC_OFF_VECT_ADDR: v = vect_addr_q;
				VIC_OFF_DEF_VECT: v = def_vect_q;
				VIC_OFF_EDGE_STAT: v = edge_stat_q[31:0];
				VIC_OFF_EDGE_STAT + 12'h004: v = edge_stat_q[63:32];
				VIC_OFF_EDGE_MASK: v = edge_mask_q[31:0];
				VIC_OFF_EDGE_MASK + 12'h004: v = edge_mask_q[63:32];
				VIC_OFF_RISE_EN: v = rise_en_q[31:0];
				VIC_OFF_RISE_EN + 12'h004: v = rise_en_q[63:32];
				VIC_OFF_FALL_EN: v = fall_en_q[31:0];
				VIC_OFF_FALL_EN + 12'h004: v = fall_en_q[63:32];
				default: v = 32'h00000000;
			endcase
		end
		return v;
	endfunction

	// ****************************************
	// Next-state logic
	// ****************************************
	logic take;
	logic [PADW-1:0] w1c;
	logic [PADW-1:0] pin_mask;

	always_comb begin
		take = hsel && htrans[1] && hready;
		pin_mask = '0;
		pin_mask[PIN_COUNT-1:0] = '1;
		enable_d = enable_q;
		class_d = class_q;
		def_vect_d = def_vect_q;
		vect_d = vect_q;
		prio_d = prio_q;
		edge_mask_d = edge_mask_q;
		rise_en_d = rise_en_q;
		fall_en_d = fall_en_q;
		w1c = '0;
		wr_pend_d = take && hwrite;
		rd_pend_d = take && !hwrite;
		addr_d = take ? haddr[11:0] : addr_q;
		hreadyout_d = !(take && !hwrite);
		hrdata_d = rd_pend_q ? rd_mux(addr_q) : hrdata_q;
		hresp_d = 1'b0;
		if (wr_pend_q) begin
			if (addr_q[11:8] == VIC_PAGE_VECT && addr_q[7] == 1'b0) begin
				vect_d[addr_q[6:2]] = hwdata;
			end else if (addr_q[11:8] == VIC_PAGE_PRIO && addr_q[7] == 1'b0) begin
				prio_d[addr_q[6:2]] = hwdata[PRIO_WIDTH-1:0];
			end else begin
				case (addr_q)
					VIC_OFF_ENABLE: enable_d = hwdata;
					VIC_OFF_CLASS: class_d = hwdata;
					VIC_OFF_DEF_VECT: def_vect_d = hwdata;
					VIC_OFF_EDGE_STAT: w1c[31:0] = hwdata;
					VIC_OFF_EDGE_STAT + 12'h004: w1c[63:32] = hwdata;
					VIC_OFF_EDGE_MASK: edge_mask_d[31:0] = hwdata;
					VIC_OFF_EDGE_MASK + 12'h004: edge_mask_d[63:32] = hwdata;
					VIC_OFF_RISE_EN: rise_en_d[31:0] = hwdata;
					VIC_OFF_RISE_EN + 12'h004: rise_en_d[63:32] = hwdata;
					VIC_OFF_FALL_EN: fall_en_d[31:0] = hwdata;
					VIC_OFF_FALL_EN + 12'h004: fall_en_d[63:32] = hwdata;
					default: enable_d = enable_q;
				endcase
			end
		end
		rise_en_d = rise_en_d & pin_mask;
		fall_en_d = fall_en_d & pin_mask;
		edge_mask_d = edge_mask_d & pin_mask;
		// Set wins over a clear in the same cycle
		edge_stat_d = (edge_stat_q & ~w1c) | edge_hit;
		edge_irq_d = |(edge_stat_q & edge_mask_q);
		fast_irq_d = |fast_active;
		irq_d = |norm_active;
		vect_addr_d = win_valid ? vect_q[win_idx] : def_vect_q;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			enable_q <= VIC_RST_WORD;
			class_q <= VIC_RST_WORD;
			def_vect_q <= VIC_RST_WORD;
			vect_addr_q <= VIC_RST_WORD;
			for (int i = 0; i < VIC_CHANNELS; i++) begin
				vect_q[i] <= VIC_RST_WORD;
				prio_q[i] <= PRIO_WIDTH'(VIC_RST_PRIO);
			end
			edge_stat_q <= '0;
			edge_mask_q <= '0;
			rise_en_q <= '0;
			fall_en_q <= '0;
			edge_irq_q <= 1'b0;
			fast_irq_q <= 1'b0;
			irq_q <= 1'b0;
			hrdata_q <= VIC_RST_WORD;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 12'h000;
		end else begin
			enable_q <= enable_d;
			class_q <= class_d;
			def_vect_q <= def_vect_d;
			vect_addr_q <= vect_addr_d;
			vect_q <= vect_d;
			prio_q <= prio_d;
			edge_stat_q <= edge_stat_d;
			edge_mask_q <= edge_mask_d;
			rise_en_q <= rise_en_d;
			fall_en_q <= fall_en_d;
			edge_irq_q <= edge_irq_d;
			fast_irq_q <= fast_irq_d;
			irq_q <= irq_d;
			hrdata_q <= hrdata_d;
			hreadyout_q <= hreadyout_d;
			hresp_q <= hresp_d;
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			addr_q <= addr_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign fast_interrupt_request = fast_irq_q;
	assign normal_interrupt_request = irq_q;
	assign edge_irq = edge_irq_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic better_exists;
	always_comb begin
		better_exists = 1'b0;
		for (int i = 0; i < VIC_CHANNELS; i++) begin
			if (norm_active[i] && win_valid && (prio_q[i] < win_prio || (prio_q[i] == win_prio && 5'(i) < win_idx))) begin
				better_exists = 1'b1;
			end
		end
	end

	sequence rd_taken_s;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence rd_answer_s;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence wr_taken_s;
		hsel && htrans[1] && hready && hwrite;
	endsequence
	sequence edge_seen_s;
		edge_hit != '0;
	endsequence

	fast_or_a: assert property (##1 fast_interrupt_request == $past(|fast_active))
		else $error("fast output does not follow fast requests");
	normal_or_a: assert property (##1 normal_interrupt_request == $past(|norm_active))
		else $error("normal output does not follow vectored requests");
	class_split_a: assert property ((fast_active & norm_active) == 32'h00000000)
		else $error("request counted in both classes");
	low_channel_a: assert property (!better_exists)
		else $error("vectored winner is not the best channel");
	vect_addr_a: assert property (win_valid |=> vect_addr_q == $past(vect_q[win_idx]))
		else $error("vector address does not match winner");
	fast_drop_a: assert property (!(|fast_active) [*2] |=> !fast_interrupt_request)
		else $error("fast output stays high with no fast request");
	edge_set_a: assert property (edge_seen_s |=> ((edge_stat_q & $past(edge_hit)) == $past(edge_hit)))
		else $error("enabled edge did not set its status bit");
	ext_merge_a: assert property (edge_irq && enable_q[EXT_CHANNEL] && !class_q[EXT_CHANNEL] |=> normal_interrupt_request)
		else $error("edge request missing on external channel");
	class_write_a: assert property (wr_pend_q && addr_q == VIC_OFF_CLASS |=> class_q == $past(hwdata))
		else $error("class write did not take effect");
	read_wait_a: assert property (rd_taken_s |=> rd_answer_s)
		else $error("read answer timing wrong");

	// ****************************************
	// Bus and arbitration checks
	// ****************************************
	write_wait_a: assert property (wr_taken_s |=> hreadyout)
		else $error("write data phase was stretched");
	wait_once_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	okay_resp_a: assert property (!hresp)
		else $error("error response given");
	fast_excl_a: assert property (win_valid |-> !class_q[win_idx])
		else $error("fast channel won vectored arbitration");
	winner_active_a: assert property (win_valid |-> norm_active[win_idx])
		else $error("vectored winner is not an active request");
	def_vect_a: assert property (!win_valid |=> vect_addr_q == $past(def_vect_q))
		else $error("default vector not shown when idle");
	norm_drop_a: assert property (!(|norm_active) [*2] |=> !normal_interrupt_request)
		else $error("normal output stays high with no vectored request");
	prio_write_a: assert property (wr_pend_q && addr_q[11:8] == VIC_PAGE_PRIO && !addr_q[7] |=> prio_q[$past(addr_q[6:2])] == $past(hwdata[PRIO_WIDTH-1:0]))
		else $error("priority write did not take effect");

	// ****************************************
	// Edge status checks
	// ****************************************
	edge_sticky_a: assert property (##1 (($past(edge_stat_q & ~w1c) & ~edge_stat_q) == '0))
		else $error("edge status bit lost without a clear");
	edge_pad_a: assert property ((edge_stat_q & ~pin_mask) == '0)
		else $error("edge status set above the pin count");
	edge_mask_a: assert property (edge_irq |-> ($past(edge_stat_q & edge_mask_q) != '0))
		else $error("edge interrupt without unmasked status");
endmodule
`default_nettype wire

/* vic_pkg.sv */
// Constants shared by the vectored interrupt controller files
`default_nettype none
package vic_pkg;
	localparam int VIC_CHANNELS = 32;
	localparam int VIC_PIN_WORDS = 2;
	localparam logic [11:0] VIC_OFF_RAW = 12'h000;
	localparam logic [11:0] VIC_OFF_ENABLE = 12'h004;
	localparam logic [11:0] VIC_OFF_CLASS = 12'h008;
	localparam logic [11:0] VIC_OFF_FAST_STAT = 12'h00c;
	localparam logic [11:0] VIC_OFF_NORM_STAT = 12'h010;
	localparam logic [11:0] VIC_OFF_VECT_ADDR = 12'h014;
	localparam logic [11:0] VIC_OFF_DEF_VECT = 12'h018;
	localparam logic [11:0] VIC_OFF_EDGE_STAT = 12'h020;
	localparam logic [11:0] VIC_OFF_EDGE_MASK = 12'h028;
	localparam logic [11:0] VIC_OFF_RISE_EN = 12'h030;
	localparam logic [11:0] VIC_OFF_FALL_EN = 12'h038;
	localparam logic [3:0] VIC_PAGE_VECT = 4'h1;
	localparam logic [3:0] VIC_PAGE_PRIO = 4'h2;
	localparam logic [31:0] VIC_RST_WORD = 32'h00000000;
	localparam logic [3:0] VIC_RST_PRIO = 4'hf;
endpackage
`default_nettype wire

/* vic_edge_detect.sv */
// Pin synchroniser and edge detector for the port edge interrupts
`default_nettype none
module vic_edge_detect #(
	parameter int WIDTH = 46
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pins,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta_q, meta_d;
	logic [WIDTH-1:0] sync_q, sync_d;
	logic [WIDTH-1:0] last_q, last_d;
	logic [WIDTH-1:0] rise_q, rise_d;
	logic [WIDTH-1:0] fall_q, fall_d;
	logic [2:0] fill_q, fill_d;

	always_comb begin
		meta_d = pins;
		sync_d = meta_q;
		last_d = sync_q;
		// Edges held off until both compared samples are real pin values
		fill_d = {fill_q[1:0], 1'b1};
		rise_d = sync_q & ~last_q & {WIDTH{fill_q[2]}};
		fall_d = ~sync_q & last_q & {WIDTH{fill_q[2]}};
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
			rise_q <= '0;
			fall_q <= '0;
			fill_q <= 3'b000;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
			fill_q <= fill_d;
		end
	end

	assign rise = rise_q;
	assign fall = fall_q;
endmodule
`default_nettype wire

/* vic_periph_model.sv */
// Peripheral model: one request line per peripheral from two internal flags
`default_nettype none
module vic_periph_model
	import vic_pkg::*;
(
	input wire logic [VIC_CHANNELS-1:0] flag_a,
	input wire logic [VIC_CHANNELS-1:0] flag_b,
	output logic [VIC_CHANNELS-1:0] periph_req
);
	timeunit 1ns;
	timeprecision 1ns;
	// Any flag raises the single line
	assign periph_req = flag_a | flag_b;
endmodule
`default_nettype wire

/* vic_vectored_irq_ctrl_tb.sv */
// Self-checking testbench for the vectored interrupt controller
`default_nettype none
module vic_vectored_irq_ctrl_tb
	import vic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [31:0] req;
		logic [31:0] cls;
		logic fast;
		logic irq;
		logic [31:0] vec;
	} vic_row_type;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] flag_a = 32'h0;
	logic [31:0] flag_b = 32'h0;
	logic [31:0] periph_req;
	logic [45:0] port_pins = 46'h0;
	logic fast_out;
	logic irq_out;
	logic edge_irq;
	logic [31:0] rd;
	vic_row_type rows [5];
	int n_mismatch = 0;
	int tests_run = 0;
	// ********************
	// Clock, design, partner
	// ********************
	always #50 clk = ~clk;
	assign hready = hreadyout;
	vic_vectored_irq_ctrl i_vic_vectored_irq_ctrl (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .periph_req(periph_req), .port_pins(port_pins),
		.fast_interrupt_request(fast_out), .normal_interrupt_request(irq_out), .edge_irq(edge_irq));
	vic_periph_model i_vic_periph_model (.flag_a(flag_a), .flag_b(flag_b), .periph_req(periph_req));
	// ********************
	// Tasks
	// ********************
	function automatic logic [31:0] vec_of(input int n);
		return 32'h00008000 + 32'(n * 16);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h0, a};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ********************
	// Watchdog
	// ********************
	initial begin
		#(100 * 20000);
		n_mismatch++;
		finish_test();
	end
	// ********************
	// Main sequence
	// ********************
	initial begin
		rows[0] = '{32'h00000005, 32'h0, 1'b0, 1'b1, vec_of(0)};
		rows[1] = '{32'h00000006, 32'h00000002, 1'b1, 1'b1, vec_of(2)};
		rows[2] = '{32'h80000002, 32'h80000002, 1'b1, 1'b0, 32'h00000bad};
		rows[3] = '{32'h00000030, 32'h0, 1'b0, 1'b1, vec_of(4)};
		rows[4] = '{32'h0, 32'h0, 1'b0, 1'b0, 32'h00000bad};
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		port_pins <= 46'h10000000000;
		rdchk(VIC_OFF_ENABLE, 32'h0);
		rdchk(12'h204, 32'h0000000f);
		wr(VIC_OFF_ENABLE, 32'hffffffff);
		wr(VIC_OFF_DEF_VECT, 32'h00000bad);
		for (int i = 0; i < 32; i++) begin
			wr(12'h100 + 12'(4 * i), vec_of(i));
		end
		foreach (rows[k]) begin
			wr(VIC_OFF_CLASS, rows[k].cls);
			flag_a <= rows[k].req & 32'h0000ffff;
			flag_b <= rows[k].req & 32'hffff0000;
			repeat (2) @(posedge clk);
			check({31'h0, fast_out}, {31'h0, rows[k].fast});
			check({31'h0, irq_out}, {31'h0, rows[k].irq});
			rdchk(VIC_OFF_FAST_STAT, rows[k].req & rows[k].cls);
			rdchk(VIC_OFF_NORM_STAT, rows[k].req & ~rows[k].cls);
			rdchk(VIC_OFF_VECT_ADDR, rows[k].vec);
		end
		// Priority override, then disabled channel ignored
		flag_a <= 32'h00000028;
		wr(12'h214, 32'h0);
		rdchk(VIC_OFF_VECT_ADDR, vec_of(5));
		wr(12'h214, 32'h0000000f);
		rdchk(VIC_OFF_VECT_ADDR, vec_of(3));
		wr(VIC_OFF_ENABLE, 32'hfffffff7);
		rdchk(VIC_OFF_VECT_ADDR, vec_of(5));
		wr(VIC_OFF_ENABLE, 32'hffffffff);
		flag_a <= 32'h0;
		// Port edges: pin 0 rising, pin 40 falling
		wr(VIC_OFF_RISE_EN, 32'h00000001);
		wr(VIC_OFF_EDGE_MASK, 32'h00000001);
		wr(12'h03c, 32'h00000100);
		wr(12'h02c, 32'h00000100);
		port_pins <= 46'h00000000001;
		repeat (8) @(posedge clk);
		check({31'h0, edge_irq}, 32'h1);
		check({31'h0, irq_out}, 32'h1);
		rdchk(VIC_OFF_RAW, 32'h00020000);
		rdchk(VIC_OFF_EDGE_STAT, 32'h00000001);
		rdchk(12'h024, 32'h00000100);
		wr(VIC_OFF_EDGE_STAT, 32'h00000001);
		wr(12'h024, 32'h00000100);
		repeat (3) @(posedge clk);
		check({31'h0, edge_irq}, 32'h0);
		rdchk(VIC_OFF_EDGE_STAT, 32'h0);
		// Both edges on pin 33
		wr(12'h034, 32'h00000002);
		wr(12'h03c, 32'h00000102);
		port_pins <= 46'h00200000001;
		repeat (6) @(posedge clk);
		rdchk(12'h024, 32'h00000002);
		wr(12'h024, 32'h00000002);
		port_pins <= 46'h00000000001;
		repeat (6) @(posedge clk);
		rdchk(12'h024, 32'h00000002);
		// Mid-run reset with requests standing and pin 0 high
		wr(12'h214, 32'h00000003);
		wr(VIC_OFF_CLASS, 32'h00000001);
		flag_a <= 32'h00000003;
		repeat (2) @(posedge clk);
		check({31'h0, fast_out}, 32'h1);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		check({31'h0, fast_out}, 32'h0);
		check({31'h0, irq_out}, 32'h0);
		nrst <= 1'b1;
		wr(VIC_OFF_RISE_EN, 32'h00000001);
		repeat (4) @(posedge clk);
		check({31'h0, irq_out}, 32'h0);
		rdchk(VIC_OFF_EDGE_STAT, 32'h0);
		rdchk(VIC_OFF_ENABLE, 32'h0);
		rdchk(12'h214, 32'h0000000f);
		rdchk(VIC_OFF_VECT_ADDR, 32'h0);
		rdchk(12'h0fc, 32'h0);
		check({31'h0, hresp}, 32'h0);
		finish_test();
	end
endmodule
`default_nettype wire
